// file: hw/osc_clk_defs.svh
`ifndef OSC_CLK_DEFS_SVH
`define OSC_CLK_DEFS_SVH
// Register byte addresses, each an 8-bit register in the low byte lane
`define ADDR_TIMER_CLK_CTRL 16'h5065
`define IDX_TIMER_CLK_CTRL 16'h5065
`define ADDR_FAST_OUT_CTRL 16'h5064
`define ADDR_OSC_CTRL 16'h5060
`define ADDR_SRC_SEL 16'h5061
`define ADDR_PORT1_FUNC 16'h52A1
`define ADDR_PORT3_FUNC 16'h52A3
`define ADDR_STATUS 16'h5070
// Field positions
`define FOUT_SLOW_EN_BIT 0
`define FOUT_FAST_EN_BIT 1
`define FOUT_DIV_LSB 2
`define TMR_GATE_BIT 0
`define TMR_DIV_LSB 1
`define PORT3_BIT0_SEL 0
`define PORT1_BIT3_SEL 3
`define OSC_FAST_EXT_BIT 0
`define OSC_SLOW_BIT 1
`define OSC_INT_BIT 2
`define SRC_SYS_BIT 0
`define SRC_FAST_BIT 1
// Reset values
`define FOUT_RESET 8'h00
`define TMR_RESET 8'h00
`define OSC_RESET 8'h07
`define SRC_RESET 8'h00
`define PORT_RESET 8'h00
// Highest legal divider codes
`define TMR_DIV_MAX 3'h5
`define FOUT_DIV_MAX 2'h2
// Stabilization waits in cycles of the oscillator being waited on (slow or fast)
`define SLOW_STAB_CYCLES 256
`define FAST_STAB_DEFAULT 1024
`endif

// file: hw/osc_clk_pkg.sv
package osc_clk_pkg;
  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_WAIT = 3'b010,
    SW_DONE = 3'b100
  } stab_state_t;
endpackage

// file: hw/osc_clock_output_and_switch_ctrl.sv
`timescale 1ns/1ps
`include "osc_clk_defs.svh"
// Summary of operation
// - Fast clock output follows its enable bit
// - Fast output pin needs port3 bit0 select
// - Slow clock output follows its enable bit
// - Slow output pin needs port1 bit3 select
// - Timer divider codes 0-5 divide by 1-32
// - Timer clock gate enables timer clock
// - Slow clock withheld from the system 256 cycles after re-enable
// - External fast clock withheld for its wait
// - Disabling the active oscillator is ignored
// - Output gates unsynchronized, glitches possible
// - Fast select changes only with both running
// - System select changes only with slow and selected fast osc running
// - Three allowed oscillator combinations for switching
// - Fast output divider codes 0-2 divide 1,2,4
module osc_clock_output_and_switch_ctrl #(
  parameter int FAST_STAB = `FAST_STAB_DEFAULT,
  parameter int STAB_W = 12
) (
  input wire logic sys_clk, // 20 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic [15:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte enables
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic fast_clk_tick, // One pulse per fast clock cycle
  input wire logic slow_clk_tick, // One pulse per slow clock cycle
  input wire logic int_osc_running, // Internal osc started
  input wire logic ext_osc_running, // External fast osc started
  input wire logic slow_osc_running, // Slow osc started
  input wire logic port30_gpio_out, // Port 3 bit 0 data
  input wire logic port13_gpio_out, // Port 1 bit 3 data
  output logic fast_clk_out_pin, // Pin shared with port3 bit0
  output logic slow_clk_out_pin, // Pin shared with port1 bit3
  output logic timer_clk_tick, // Gated timer clock enable
  output logic sysclk_src_select, // 1 = fast clock is system
  output logic fast_src_select, // 1 = external fast osc
  output logic sysclk_feed_ok // Selected clock may feed system
);
  logic [7:0] fout_r;
  logic [7:0] tmr_r;
  logic [7:0] osc_r;
  logic [7:0] src_r;
  logic [7:0] p1_r;
  logic [7:0] p3_r;
  logic rd_pend_r;
  logic [31:0] rdata_r;
  logic [4:0] tdiv_r;
  logic [1:0] fdiv_r;
  logic fast_half_r;
  logic slow_half_r;
  logic tmr_tick_r;
  logic slow_stable;
  logic fast_stable;
  logic wr_en;
  logic [7:0] wb;
  logic int_on;
  logic ext_on;
  logic slow_on;
  logic int_act;
  logic ext_act;
  logic slow_act;
  logic sw_ok;
  logic hs_ok;
  logic [7:0] osc_nxt;
  logic fast_div_tick;
  logic [2:0] tsel;
  logic tap;

  // Writes land in the low byte only; upper lanes read zero
  assign wr_en = avs_write && avs_byteenable[0];
  assign wb = avs_writedata[7:0];
  assign int_on = osc_r[`OSC_INT_BIT];
  assign ext_on = osc_r[`OSC_FAST_EXT_BIT];
  assign slow_on = osc_r[`OSC_SLOW_BIT];
  // Running means enabled and oscillating; an enable alone is not enough
  assign int_act = int_on && int_osc_running;
  assign ext_act = ext_on && ext_osc_running;
  assign slow_act = slow_on && slow_osc_running;

  // Reads answer one cycle later, writes immediately
  assign avs_waitrequest = avs_read && !rd_pend_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= avs_read && !rd_pend_r;
    end
  end

  // Switching allowed only for the permitted oscillator combinations
  always_comb begin
    hs_ok = int_act && ext_act;
    sw_ok = slow_act && ((int_act && ext_act) ||
            (int_act && !ext_act && !src_r[`SRC_FAST_BIT]) ||
            (!int_act && ext_act && src_r[`SRC_FAST_BIT]));
  end

  // Oscillator in use as system clock cannot be switched off
  always_comb begin
    osc_nxt = wb & 8'h07;
    if (src_r[`SRC_SYS_BIT]) begin
      if (src_r[`SRC_FAST_BIT]) begin
        osc_nxt[`OSC_FAST_EXT_BIT] = 1'b1;
      end else begin
        osc_nxt[`OSC_INT_BIT] = 1'b1;
      end
    end else begin
      osc_nxt[`OSC_SLOW_BIT] = 1'b1;
    end
  end

  // Control register writes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fout_r <= `FOUT_RESET;
      tmr_r <= `TMR_RESET;
      osc_r <= `OSC_RESET;
      p1_r <= `PORT_RESET;
      p3_r <= `PORT_RESET;
    end else if (wr_en) begin
      case (avs_address)
        `ADDR_FAST_OUT_CTRL: fout_r <= wb & 8'h0F;
        `ADDR_TIMER_CLK_CTRL: tmr_r <= wb & 8'h0F;
        `ADDR_OSC_CTRL: osc_r <= osc_nxt;
        `ADDR_PORT1_FUNC: p1_r <= wb;
        `ADDR_PORT3_FUNC: p3_r <= wb;
        default: ;
      endcase
    end
  end

  // Source selects refuse writes when the switch conditions fail
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      src_r <= `SRC_RESET;
    end else if (wr_en && avs_address == `ADDR_SRC_SEL) begin
      if (hs_ok) begin
        src_r[`SRC_FAST_BIT] <= wb[`SRC_FAST_BIT];
      end
      if (sw_ok) begin
        src_r[`SRC_SYS_BIT] <= wb[`SRC_SYS_BIT];
      end
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h0;
    end else if (avs_read) begin
      case (avs_address)
        `ADDR_FAST_OUT_CTRL: rdata_r <= {24'h0, fout_r};
        `ADDR_TIMER_CLK_CTRL: rdata_r <= {24'h0, tmr_r};
        `ADDR_OSC_CTRL: rdata_r <= {24'h0, osc_r};
        `ADDR_SRC_SEL: rdata_r <= {24'h0, src_r};
        `ADDR_PORT1_FUNC: rdata_r <= {24'h0, p1_r};
        `ADDR_PORT3_FUNC: rdata_r <= {24'h0, p3_r};
        `ADDR_STATUS: rdata_r <= {26'h0, fast_stable, slow_stable,
                                  sysclk_feed_ok, slow_osc_running,
                                  ext_osc_running, int_osc_running};
        default: rdata_r <= 32'h0;
      endcase
    end
  end
  assign avs_readdata = rdata_r;

  // Fast clock output divider: 1, 2 or 4 via counter taps
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fdiv_r <= 2'h0;
      fast_half_r <= 1'b0;
    end else if (fast_clk_tick) begin
      fdiv_r <= fdiv_r + 2'h1;
      case (fout_r[`FOUT_DIV_LSB +: 2])
        2'h0: fast_half_r <= ~fast_half_r;
        2'h1: fast_half_r <= fdiv_r[0] ? ~fast_half_r : fast_half_r;
        2'h2: fast_half_r <= (fdiv_r == 2'h3) ? ~fast_half_r
                                               : fast_half_r;
        default: fast_half_r <= fast_half_r;
      endcase
    end
  end
  assign fast_div_tick = fast_half_r;

  // Slow clock output toggles each slow cycle, undivided
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slow_half_r <= 1'b0;
    end else if (slow_clk_tick) begin
      slow_half_r <= ~slow_half_r;
    end
  end

  // Gates follow enables directly, so an edit mid-cycle may chop a pulse
  always_comb begin
    fast_clk_out_pin = port30_gpio_out;
    if (p3_r[`PORT3_BIT0_SEL]) begin
      fast_clk_out_pin = fout_r[`FOUT_FAST_EN_BIT]
                         && fast_div_tick;
    end
    slow_clk_out_pin = port13_gpio_out;
    if (p1_r[`PORT1_BIT3_SEL]) begin
      slow_clk_out_pin = fout_r[`FOUT_SLOW_EN_BIT]
                         && slow_half_r;
    end
  end

  // Free-running timer prescaler on the slow clock
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tdiv_r <= 5'h00;
    end else if (slow_clk_tick) begin
      tdiv_r <= tdiv_r + 5'h01;
    end
  end

  // Tap select: divide by 2^code, reserved codes give no clock
  always_comb begin
    tsel = tmr_r[`TMR_DIV_LSB +: 3];
    case (tsel)
      3'h0: tap = 1'b1;
      3'h1: tap = tdiv_r[0] == 1'b1;
      3'h2: tap = tdiv_r[1:0] == 2'h3;
      3'h3: tap = tdiv_r[2:0] == 3'h7;
      3'h4: tap = tdiv_r[3:0] == 4'hF;
      3'h5: tap = tdiv_r[4:0] == 5'h1F;
      default: tap = 1'b0;
    endcase
  end

  // Timer clock gate
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tmr_tick_r <= 1'b0;
    end else begin
      tmr_tick_r <= slow_clk_tick && tap
                    && tmr_r[`TMR_GATE_BIT];
    end
  end
  assign timer_clk_tick = tmr_tick_r;

  // Stabilization waits before a fresh oscillator feeds the system
  stab_waiter #(.CW(STAB_W)) u_slow_wait (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .osc_on(slow_on),
    .osc_running(slow_osc_running),
    .tick(slow_clk_tick),
    .wait_cycles(STAB_W'(`SLOW_STAB_CYCLES)),
    .stable(slow_stable)
  );

  stab_waiter #(.CW(STAB_W)) u_fast_wait (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .osc_on(ext_on),
    .osc_running(ext_osc_running),
    .tick(fast_clk_tick),
    .wait_cycles(STAB_W'(FAST_STAB)),
    .stable(fast_stable)
  );

  // Feed only once the selected source has settled
  always_comb begin
    if (!src_r[`SRC_SYS_BIT]) begin
      sysclk_feed_ok = slow_stable;
    end else if (src_r[`SRC_FAST_BIT]) begin
      sysclk_feed_ok = fast_stable;
    end else begin
      sysclk_feed_ok = int_osc_running;
    end
  end

  assign sysclk_src_select = src_r[`SRC_SYS_BIT];
  assign fast_src_select = src_r[`SRC_FAST_BIT];
endmodule

// file: hw/stab_waiter.sv
`timescale 1ns/1ps
// Counts stabilization cycles after an oscillator reports it is running
module stab_waiter #(
  parameter int CW = 12
) (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic osc_on, // Oscillator enabled
  input wire logic osc_running, // Oscillation started
  input wire logic tick, // Count enable (one pulse per osc cycle)
  input wire logic [CW-1:0] wait_cycles, // Cycles to wait
  output logic stable // Clock may be fed
);
  osc_clk_pkg::stab_state_t st_r;
  logic [CW-1:0] cnt_r;

  // Restart whenever the oscillator is switched off
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= osc_clk_pkg::SW_DONE;
      cnt_r <= '0;
    end else if (!osc_on) begin
      st_r <= osc_clk_pkg::SW_IDLE;
      cnt_r <= '0;
    end else begin
      case (st_r)
        osc_clk_pkg::SW_IDLE: begin
          if (osc_running) begin
            st_r <= osc_clk_pkg::SW_WAIT;
          end
        end
        osc_clk_pkg::SW_WAIT: begin
          if (tick) begin
            if (cnt_r + 1'b1 >= wait_cycles) begin
              st_r <= osc_clk_pkg::SW_DONE;
            end
            cnt_r <= cnt_r + 1'b1;
          end
        end
        osc_clk_pkg::SW_DONE: st_r <= osc_clk_pkg::SW_DONE;
        default: st_r <= osc_clk_pkg::SW_IDLE;
      endcase
    end
  end

  assign stable = (st_r == osc_clk_pkg::SW_DONE);
endmodule

// file: testbench/occ_assertions.sv
`timescale 1ns/1ps
// Port checks; shadow bits follow written selects
module occ_chk (
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Reset
  input wire logic [15:0] avs_address, // Addr
  input wire logic avs_write, // Wr
  input wire logic [31:0] avs_writedata, // Data
  input wire logic [3:0] avs_byteenable, // Lanes
  input wire logic slow_clk_tick, // Tick
  input wire logic int_osc_running, // Int
  input wire logic ext_osc_running, // Ext
  input wire logic slow_osc_running, // Slow
  input wire logic port30_gpio_out, // Gpio
  input wire logic port13_gpio_out, // Gpio
  input wire logic fast_clk_out_pin, // Pin
  input wire logic slow_clk_out_pin, // Pin
  input wire logic timer_clk_tick, // Timer
  input wire logic sysclk_src_select, // Sys
  input wire logic fast_src_select // Fast
);
  logic s3_r, s1_r, fe_r, se_r;
  // Writes never stall, so lane 0 with write is taken
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {s3_r, s1_r, fe_r, se_r} <= 4'h0;
    end else if (avs_write && avs_byteenable[0]) begin
      if (avs_address == 16'h52A3) s3_r <= avs_writedata[0];
      if (avs_address == 16'h52A1) s1_r <= avs_writedata[3];
      if (avs_address == 16'h5064) {fe_r, se_r} <= avs_writedata[1:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_fgpio;
    !s3_r |-> fast_clk_out_pin == port30_gpio_out;
  endproperty
  a_fgpio: assert property (p_fgpio) else $error("fast gpio");
  property p_sgpio;
    !s1_r |-> slow_clk_out_pin == port13_gpio_out;
  endproperty
  a_sgpio: assert property (p_sgpio) else $error("slow gpio");
  property p_foff;
    s3_r && !fe_r |-> !fast_clk_out_pin;
  endproperty
  a_foff: assert property (p_foff) else $error("fast off");
  property p_soff;
    s1_r && !se_r |-> !slow_clk_out_pin;
  endproperty
  a_soff: assert property (p_soff) else $error("slow off");
  property p_tmr;
    timer_clk_tick |-> $past(slow_clk_tick);
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer tick");
  property p_fsel;
    $changed(fast_src_select) |->
      $past(avs_write && int_osc_running && ext_osc_running);
  endproperty
  a_fsel: assert property (p_fsel) else $error("fast sel");
  property p_ssel;
    $changed(sysclk_src_select) |-> $past(avs_write && slow_osc_running);
  endproperty
  a_ssel: assert property (p_ssel) else $error("sys sel");
  property p_comb;
    $changed(sysclk_src_select) |-> $past(
      (int_osc_running && ext_osc_running) ||
      (int_osc_running && !fast_src_select) ||
      (ext_osc_running && fast_src_select));
  endproperty
  a_comb: assert property (p_comb) else $error("sys combo");
endmodule
bind osc_clock_output_and_switch_ctrl occ_chk i_occ_chk (.*);

// file: testbench/occ_far_model.sv
`timescale 1ns/1ps
// Oscillator ticks and the timer that counts its clock
module occ_far_model (
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Reset
  input wire logic timer_clk_tick, // Timer clock
  output logic fast_clk_tick, // Every 2nd cycle
  output logic slow_clk_tick, // Every 4th cycle
  output logic [15:0] tmr_count // Ticks seen
);
  logic [1:0] ph_r;
  // Fixed periods keep counts per window exact
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ph_r <= 2'h0;
      tmr_count <= 16'h0;
    end else begin
      ph_r <= ph_r + 2'h1;
      tmr_count <= tmr_count + {15'h0, timer_clk_tick};
    end
  end
  assign fast_clk_tick = ph_r[0];
  assign slow_clk_tick = (ph_r == 2'h3);
endmodule

// file: testbench/osc_clock_output_and_switch_ctrl_tb_top.sv
`timescale 1ns/1ps
module osc_clock_output_and_switch_ctrl_tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] avs_address = 16'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic int_osc_running = 1'b1;
  logic ext_osc_running = 1'b1;
  logic slow_osc_running = 1'b1;
  logic port30_gpio_out = 1'b0;
  logic port13_gpio_out = 1'b0;
  logic [31:0] avs_readdata, q, r;
  logic avs_waitrequest, fast_clk_tick, slow_clk_tick, timer_clk_tick;
  logic fast_clk_out_pin, slow_clk_out_pin, sysclk_feed_ok;
  logic sysclk_src_select, fast_src_select, ef, es;
  logic [15:0] tmr_count, n0;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int t;
  osc_clock_output_and_switch_ctrl #(.FAST_STAB(8))
    i_osc_clock_output_and_switch_ctrl (.*);
  occ_far_model i_occ_far_model (.sys_clk(sys_clk), .resetn(resetn),
    .timer_clk_tick(timer_clk_tick), .fast_clk_tick(fast_clk_tick),
    .slow_clk_tick(slow_clk_tick), .tmr_count(tmr_count));
  always #25 sys_clk = ~sys_clk;
  // Runaway guard, far above the few thousand cycles needed
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic finish_test;
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  // Held until an edge samples waitrequest low; read data taken there
  task automatic bus(input logic rd, input logic [15:0] a,
                     input logic [7:0] d);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h0, d};
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    bus(1'b1, a, 8'h0);
    check(q, {24'h0, e});
  endtask
  // Counts pin changes over n cycles
  task automatic tgl(input logic f, input int n);
    logic p;
    @(negedge sys_clk);
    p = f ? fast_clk_out_pin : slow_clk_out_pin;
    t = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if ((f ? fast_clk_out_pin : slow_clk_out_pin) !== p) t++;
      p = f ? fast_clk_out_pin : slow_clk_out_pin;
    end
    @(posedge sys_clk);
  endtask
  // Phase of the divider may shift one edge in or out of the window
  task automatic near(input int e);
    check({31'h0, t + 1 >= e && t <= e + 1}, 32'h1);
  endtask
  function automatic int tmr_exp(input logic [2:0] c, input logic g);
    return (g && c <= 3'h5) ? (64 >> c) : 0;
  endfunction
  function automatic logic sw_ok(input logic i, e, s, f);
    return s && ((i && e) || (i && !e && !f) || (!i && e && f));
  endfunction
  initial begin
    void'($urandom(32'h7aa34b46));
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rdc(16'h5065, 8'h00);
    rdc(16'h5064, 8'h00);
    bus(1'b0, 16'h5065, 8'hFF);
    rdc(16'h5065, 8'h0F);
    rdc(16'h5100, 8'h00);
    repeat (8) begin
      r = $urandom;
      port30_gpio_out <= r[0];
      port13_gpio_out <= r[1];
      @(negedge sys_clk);
      check({slow_clk_out_pin, fast_clk_out_pin}, r[1:0]);
      @(posedge sys_clk);
    end
    bus(1'b0, 16'h52A3, 8'h01);
    bus(1'b0, 16'h52A1, 8'h08);
    tgl(1'b1, 32);
    check(t, 0);
    bus(1'b0, 16'h5064, 8'h01);
    tgl(1'b0, 64);
    near(16);
    for (int c = 0; c < 3; c++) begin
      bus(1'b0, 16'h5064, 8'(c * 4 + 2));
      tgl(1'b1, 128);
      near(64 >> c);
    end
    for (int k = 0; k < 16; k++) begin
      bus(1'b0, 16'h5065, 8'(k));
      repeat (8) @(posedge sys_clk);
      n0 = tmr_count;
      repeat (256) @(posedge sys_clk);
      check(tmr_count - n0, tmr_exp(k[3:1], k[0]));
    end
    for (int k = 0; k < 24; k++) begin
      r = $urandom;
      {int_osc_running, ext_osc_running, slow_osc_running} <=
        r[2:0] | r[5:3];
      ef = ((r[2] | r[5]) && (r[1] | r[4])) ? r[9] : fast_src_select;
      es = sw_ok(r[2] | r[5], r[1] | r[4], r[0] | r[3], fast_src_select)
        ? r[8] : sysclk_src_select;
      bus(1'b0, 16'h5061, {6'h0, r[9:8]});
      check({fast_src_select, sysclk_src_select}, {ef, es});
      rdc(16'h5061, {6'h0, ef, es});
    end
    // LCD gate order is left to software, none lives here
    {int_osc_running, ext_osc_running, slow_osc_running} <= 3'h7;
    bus(1'b0, 16'h5061, 8'h01);
    bus(1'b0, 16'h5060, 8'h00);
    rdc(16'h5060, 8'h04);
    bus(1'b0, 16'h5060, 8'h07);
    bus(1'b0, 16'h5061, 8'h00);
    bus(1'b0, 16'h5060, 8'h00);
    rdc(16'h5060, 8'h02);
    // Slow osc restarted a few cycles ago; 256 slow ticks before feeding
    check(sysclk_feed_ok, 0);
    repeat (1100) @(posedge sys_clk);
    check(sysclk_feed_ok, 1);
    // External fast osc restarted, then chosen as system clock
    bus(1'b0, 16'h5060, 8'h07);
    bus(1'b0, 16'h5061, 8'h03);
    check(sysclk_feed_ok, 0);
    repeat (40) @(posedge sys_clk);
    check(sysclk_feed_ok, 1);
    finish_test();
  end
endmodule
